// ===== dqc_regs.svh
/*
 * Register offsets, field positions, reset values and codes of the
 * acquisition card host-port logic.
 * Assumes it is included by its bare name and holds definitions only.
 */
`ifndef DQC_REGS_SVH
`define DQC_REGS_SVH

`define DQC_OFS_TRIG_RES_LO  4'h0
`define DQC_OFS_RES_HI       4'h1
`define DQC_OFS_DIG_LO       4'h3
`define DQC_OFS_AO_LO        4'h4
`define DQC_OFS_AO_HI        4'h5
`define DQC_OFS_STATUS       4'h8
`define DQC_OFS_CONTROL      4'h9
`define DQC_OFS_DIG_HI       4'hB

`define DQC_CTL_SEL_LO       0
`define DQC_CTL_SEL_HI       1
`define DQC_CTL_DMA_EN       2
`define DQC_CTL_LVL_LSB      4
`define DQC_CTL_LVL_MSB      6
`define DQC_CTL_IRQ_EN       7

`define DQC_SEL_EXTERNAL     2'h2
`define DQC_SEL_PACER        2'h3

`define DQC_CONTROL_RESET    8'h00
`define DQC_DOUT_RESET       16'h0000
`define DQC_AO_RESET         12'h000
`define DQC_LVL_FIRST        3'h2

`define DQC_AO_LO_MSB        7
`define DQC_AO_LO_LSB        4

`endif

// ===== dqc_pkg.sv
/*
 * Types shared by the acquisition card host-port logic.
 * Assumes the register header is compiled alongside it.
 */
package dqc_pkg;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [3:0] addr;
      logic [7:0] wdata;
   } dqc_bus_req_t;

   typedef struct packed {
      logic [11:0] code;
      logic [3:0]  chan;
   } dqc_result_t;

   typedef enum logic [1:0] {
      DQC_DMA_IDLE  = 2'b00,
      DQC_DMA_FIRST = 2'b01,
      DQC_DMA_GAP   = 2'b10,
      DQC_DMA_SECND = 2'b11
   } dqc_dma_state_t;

endpackage

// ===== dqc_rise.sv
/*
 * Rising-edge detector giving a one-cycle pulse.
 * Assumes its input is already synchronous to ref_clk.
 */
`timescale 1ns/1ps

module dqc_rise (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic level,
   output logic      rise
);
   logic level_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         level_q <= 1'b0;
         rise    <= 1'b0;
      end else begin
         level_q <= level;
         rise    <= level & ~level_q;
      end
   end
endmodule // dqc_rise

// ===== dqc_dma.sv
/*
 * Sequencer that raises two successive DMA requests per conversion.
 * Assumes the DMA controller acknowledges each request with a one-cycle
 * dma_ack pulse while the request is high.
 */
`timescale 1ns/1ps

module dqc_dma
   import dqc_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic start,
   input  wire logic dma_ack,
   output logic      dma_req,
   output logic      busy
);
   dqc_dma_state_t state_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= DQC_DMA_IDLE;
      end else begin
         unique case (state_q)
            DQC_DMA_IDLE: begin
               if (start) state_q <= DQC_DMA_FIRST;
            end
            DQC_DMA_FIRST: begin
               if (dma_ack) state_q <= DQC_DMA_GAP;
            end
            DQC_DMA_GAP: begin
               state_q <= DQC_DMA_SECND;
            end
            DQC_DMA_SECND: begin
               if (dma_ack) state_q <= DQC_DMA_IDLE;
            end
         endcase
      end
   end

   // The request drops one cycle between the two bytes so the controller
   // sees two distinct requests.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dma_req <= 1'b0;
         busy    <= 1'b0;
      end else begin
         dma_req <= (state_q == DQC_DMA_IDLE && start)
                 || (state_q == DQC_DMA_FIRST && !dma_ack)
                 || (state_q == DQC_DMA_GAP)
                 || (state_q == DQC_DMA_SECND && !dma_ack);
         busy    <= (state_q != DQC_DMA_IDLE) || start;
      end
   end
endmodule // dqc_dma

// ===== dqc_host_port.sv
/*
 * Host-port logic of a data acquisition card: conversion trigger select,
 * result and status ports, interrupt and DMA requests, double-buffered
 * analog output code and 16-bit digital input and output ports.
 * Assumes a synchronous I/O bus whose read and write strobes are
 * one-cycle pulses, an external converter that reports busy and done,
 * and an external pacer timer whose output arrives on pacer_out.
 */
// Overview of operation
// - Control low bits choose trigger source.
// - Software mode: any offset-zero write starts conversion.
// - Pacer mode: cascaded timer output starts conversions.
// - External mode: rising trigger edge starts conversion.
// - Completed conversion sets data-valid status flag.
// - Status port write clears data-valid flag.
// - Conversion-done bit follows converter state directly.
// - Interrupt enabled: conversion end raises selected interrupt.
// - Status write drops interrupt and re-arms it.
// - Analog code: low nibble from bits 7-4.
// - Low byte buffered; high byte write updates output.
// - Digital reads return 16 input lines.
// - Inputs unlatched; bus driven only on read.
// - Digital writes latch 16 output bits.
// - Result low nibble, channel, high byte layout.
// - Status reports done, input mode, flag, channel.
// - DMA enabled: interrupt on terminal count instead.
// - DMA enabled: two requests per conversion.
`timescale 1ns/1ps
`include "dqc_regs.svh"

module dqc_host_port (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire dqc_pkg::dqc_bus_req_t bus_req,
   output logic [7:0]                bus_rdata,
   output logic                      bus_rdata_oe_n,
   input  wire logic                 pacer_out,
   input  wire logic                 external_trigger_input,
   output logic                      adc_start,
   input  wire logic                 adc_busy,
   input  wire logic                 adc_done,
   input  wire dqc_pkg::dqc_result_t adc_result,
   input  wire logic [3:0]           next_channel,
   input  wire logic                 input_differential,
   input  wire logic                 dma_ack,
   input  wire logic                 dma_tc,
   output logic                      dma_req,
   output logic [7:0]                irq_line,
   output logic [11:0]               analog_out_code,
   output logic                      analog_out_load,
   input  wire logic [15:0]          digital_input,
   output logic [15:0]               digital_output
);
   import dqc_pkg::*;

   logic [7:0]  control_q;
   logic [3:0]  ao_low_q;
   logic        data_valid_q;
   logic        irq_pending_q;
   logic        conv_done_q;
   dqc_result_t result_q;
   logic        pacer_rise;
   logic        ext_rise;
   logic        dma_busy;
   logic        dma_req_int;
   logic        trig_fire;
   logic        wr_trig;
   logic        wr_status;
   logic        wr_control;
   logic        wr_ao_lo;
   logic        wr_ao_hi;
   logic        wr_dig_lo;
   logic        wr_dig_hi;
   logic        irq_event;
   logic [1:0]  trig_sel;
   logic [2:0]  irq_level;
   logic [7:0]  status_byte;
   logic [7:0]  read_mux;
   logic        read_hit;

   assign trig_sel  = {control_q[`DQC_CTL_SEL_HI], control_q[`DQC_CTL_SEL_LO]};
   assign irq_level = control_q[`DQC_CTL_LVL_MSB:`DQC_CTL_LVL_LSB];

   // Write decode; every write strobe lasts one bus cycle.
   assign wr_trig    = bus_req.wr && bus_req.addr == `DQC_OFS_TRIG_RES_LO;
   assign wr_status  = bus_req.wr && bus_req.addr == `DQC_OFS_STATUS;
   assign wr_control = bus_req.wr && bus_req.addr == `DQC_OFS_CONTROL;
   assign wr_ao_lo   = bus_req.wr && bus_req.addr == `DQC_OFS_AO_LO;
   assign wr_ao_hi   = bus_req.wr && bus_req.addr == `DQC_OFS_AO_HI;
   assign wr_dig_lo  = bus_req.wr && bus_req.addr == `DQC_OFS_DIG_LO;
   assign wr_dig_hi  = bus_req.wr && bus_req.addr == `DQC_OFS_DIG_HI;

   dqc_rise u_pacer_rise (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .level   (pacer_out),
      .rise    (pacer_rise)
   );

   dqc_rise u_ext_rise (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .level   (external_trigger_input),
      .rise    (ext_rise)
   );

   // Only the selected source may start a conversion.
   always_comb begin
      trig_fire = 1'b0;
      if (!trig_sel[1]) begin
         trig_fire = wr_trig;
      end else if (trig_sel == `DQC_SEL_EXTERNAL) begin
         trig_fire = ext_rise;
      end else if (trig_sel == `DQC_SEL_PACER) begin
         trig_fire = pacer_rise;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         adc_start <= 1'b0;
      end else begin
         adc_start <= trig_fire;
      end
   end

   // Bit 3 has no function but is stored and reads back as written.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         control_q <= `DQC_CONTROL_RESET;
      end else if (wr_control) begin
         control_q <= bus_req.wdata;
      end
   end

   // The result is captured when the converter reports done.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         result_q <= '0;
      end else if (adc_done) begin
         result_q <= adc_result;
      end
   end

   // A completion in the same cycle as the clearing write wins.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         data_valid_q <= 1'b0;
      end else if (adc_done) begin
         data_valid_q <= 1'b1;
      end else if (wr_status) begin
         data_valid_q <= 1'b0;
      end
   end

   // The done bit is a plain copy of the converter state, never cleared
   // by software.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         conv_done_q <= 1'b0;
      end else begin
         conv_done_q <= adc_busy;
      end
   end

   // With DMA on, only the terminal count of the transfer interrupts.
   always_comb begin
      irq_event = 1'b0;
      if (control_q[`DQC_CTL_IRQ_EN]) begin
         if (control_q[`DQC_CTL_DMA_EN]) begin
            irq_event = dma_tc;
         end else begin
            irq_event = adc_done;
         end
      end
   end

   // A pending request holds until the status write re-arms it.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_pending_q <= 1'b0;
      end else if (irq_event) begin
         irq_pending_q <= 1'b1;
      end else if (wr_status) begin
         irq_pending_q <= 1'b0;
      end
   end

   // Levels below the first usable one drive no line.
   genvar lv;
   generate
      for (lv = 0; lv < 8; lv++) begin : g_irq
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               irq_line[lv] <= 1'b0;
            end else begin
               irq_line[lv] <= irq_pending_q
                  && irq_level == 3'(lv)
                  && irq_level >= `DQC_LVL_FIRST;
            end
         end
      end
   endgenerate

   dqc_dma u_dma (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .start   (adc_done && control_q[`DQC_CTL_DMA_EN]),
      .dma_ack (dma_ack),
      .dma_req (dma_req_int),
      .busy    (dma_busy)
   );

   // The request is retimed so the pin leaves a flip-flop of this module.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dma_req <= 1'b0;
      end else begin
         dma_req <= dma_req_int && dma_busy;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ao_low_q <= 4'h0;
      end else if (wr_ao_lo) begin
         ao_low_q <= bus_req.wdata[`DQC_AO_LO_MSB:`DQC_AO_LO_LSB];
      end
   end

   // The high-byte write moves the whole code to the converter at once.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         analog_out_code <= `DQC_AO_RESET;
      end else if (wr_ao_hi) begin
         analog_out_code <= {bus_req.wdata, ao_low_q};
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         analog_out_load <= 1'b0;
      end else begin
         analog_out_load <= wr_ao_hi;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         digital_output <= `DQC_DOUT_RESET;
      end else begin
         if (wr_dig_lo) begin
            digital_output[7:0] <= bus_req.wdata;
         end
         if (wr_dig_hi) begin
            digital_output[15:8] <= bus_req.wdata;
         end
      end
   end

   // Bit 7 is high while the converter is busy; bit 6 reads as zero.
   assign status_byte = {conv_done_q, 1'b0, input_differential,
                         data_valid_q, next_channel};

   always_comb begin
      read_mux = 8'h00;
      read_hit = 1'b1;
      unique case (bus_req.addr)
         `DQC_OFS_TRIG_RES_LO: read_mux = {result_q.code[3:0],
                                           result_q.chan};
         `DQC_OFS_RES_HI:      read_mux = result_q.code[11:4];
         `DQC_OFS_DIG_LO:      read_mux = digital_input[7:0];
         `DQC_OFS_DIG_HI:      read_mux = digital_input[15:8];
         `DQC_OFS_STATUS:      read_mux = status_byte;
         `DQC_OFS_CONTROL:     read_mux = control_q;
         default:              read_hit = 1'b0;
      endcase
   end

   // Inputs are sampled in the read cycle only and the bus is released
   // right after, so nothing is held between reads.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bus_rdata <= 8'h00;
      end else begin
         bus_rdata <= (bus_req.rd && read_hit) ? read_mux : 8'h00;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bus_rdata_oe_n <= 1'b1;
      end else begin
         bus_rdata_oe_n <= !(bus_req.rd && read_hit);
      end
   end
endmodule // dqc_host_port

// ===== dqc_host_port_properties.sv
/* Checker of the host-port logic, bound to its top module.
   Assumes one clock domain and one-cycle bus strobes. */
`timescale 1ns/1ps

module dqc_host_port_properties (
   input wire logic                  ref_clk,
   input wire logic                  nrst,
   input wire dqc_pkg::dqc_bus_req_t bus_req,
   input wire logic                  bus_rdata_oe_n,
   input wire logic                  external_trigger_input,
   input wire logic                  adc_start,
   input wire logic                  adc_done,
   input wire logic                  dma_tc,
   input wire logic                  dma_req,
   input wire logic [7:0]            irq_line,
   input wire logic [11:0]           analog_out_code,
   input wire logic                  analog_out_load,
   input wire logic [15:0]           digital_output
);
   import dqc_pkg::*;
   logic [7:0] ctl_q;
   logic [3:0] lo_q;
   logic [3:0] a;
   logic       w;
   logic       r;
   assign a = bus_req.addr;
   assign w = bus_req.wr;
   assign r = bus_req.rd;

   // Shadows of the control register and the buffered analog nibble.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctl_q <= 8'h00;
         lo_q  <= 4'h0;
      end else if (w && a == 4'h9) begin
         ctl_q <= bus_req.wdata;
      end else if (w && a == 4'h4) begin
         lo_q <= bus_req.wdata[7:4];
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sw_start_a: assert property (w && a == 4'h0 && !ctl_q[1]
      |=> adc_start)
      else $error("no start after trigger write");
   ext_start_a: assert property ($rose(external_trigger_input)
      && ctl_q[1:0] == 2'h2 |-> ##[1:2] adc_start)
      else $error("no start after external edge");
   bus_idle_a: assert property (!(r && a inside {4'h0, 4'h1, 4'h3,
      4'h8, 4'h9, 4'hB}) |=> bus_rdata_oe_n)
      else $error("bus driven without read");
   ao_load_a: assert property (w && a == 4'h5 |=> analog_out_load
      && analog_out_code == {$past(bus_req.wdata), lo_q})
      else $error("analog code not loaded");
   ao_hold_a: assert property (!analog_out_load
      |-> $stable(analog_out_code))
      else $error("analog code moved without load");
   dout_hi_a: assert property (w && a == 4'hB |=>
      digital_output[15:8] == $past(bus_req.wdata))
      else $error("digital high byte not latched");
   irq_set_a: assert property (adc_done && ctl_q[7] && !ctl_q[2]
      && ctl_q[6:5] != 2'h0 |-> ##2 irq_line == 8'h01 << ctl_q[6:4])
      else $error("interrupt line not raised");
   irq_clr_a: assert property (w && a == 4'h8 && !adc_done && !dma_tc
      && !$past(adc_done) && !$past(dma_tc) |-> ##2 irq_line == 8'h00)
      else $error("interrupt not dropped");
   dma_req_a: assert property (adc_done && ctl_q[2] |-> ##2 dma_req)
      else $error("no transfer request");

   cover property (adc_start);
   cover property (dma_req ##1 !dma_req);
   cover property (analog_out_load);
endmodule // dqc_host_port_properties

bind dqc_host_port dqc_host_port_properties u_dqc_host_port_properties (
   .ref_clk, .nrst, .bus_req, .bus_rdata_oe_n, .external_trigger_input,
   .adc_start, .adc_done, .dma_tc, .dma_req, .irq_line, .analog_out_code,
   .analog_out_load, .digital_output);

// ===== dqc_dma_model.sv
/* Behavioural model of the host DMA controller.
   Assumes the request is a level held until acknowledged. */
`timescale 1ns/1ps

module dqc_dma_model (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       dma_req,
   input  wire logic [2:0] ack_delay,
   output logic            dma_ack,
   output logic            dma_tc
);
   logic [2:0] wait_q;
   logic       idle_q;
   logic       odd_q;

   // One acknowledge per request, then wait for the request to drop.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wait_q  <= 3'h0;
         idle_q  <= 1'b1;
         odd_q   <= 1'b0;
         dma_ack <= 1'b0;
         dma_tc  <= 1'b0;
      end else begin
         dma_ack <= 1'b0;
         dma_tc  <= 1'b0;
         if (!dma_req) begin
            idle_q <= 1'b1;
            wait_q <= 3'h0;
         end else if (idle_q && wait_q < ack_delay) begin
            wait_q <= wait_q + 3'h1;
         end else if (idle_q) begin
            dma_ack <= 1'b1;
            idle_q  <= 1'b0;
            odd_q   <= !odd_q;
            dma_tc  <= odd_q;
         end
      end
   end
endmodule // dqc_dma_model

// ===== tb_dqc_host_port.sv
/* Testbench of the acquisition card host-port logic.
   Assumes the DMA model and the bound checker are compiled. */
`timescale 1ns/1ps

module tb_dqc_host_port;
   import dqc_pkg::*;
   typedef struct packed {
      logic [7:0] ctl;
      logic [2:0] exp;
   } dqc_tb_row_t;
   dqc_bus_req_t bus_req = '0;
   dqc_result_t  adc_result = '0;
   logic         ref_clk = 1'b0;
   logic         nrst = 1'b0;
   logic         pacer_out = 1'b0;
   logic         external_trigger_input = 1'b0;
   logic         adc_busy = 1'b0;
   logic         adc_done = 1'b0;
   logic         input_differential = 1'b1;
   logic [2:0]   ack_delay = 3'h0;
   logic [3:0]   next_channel = 4'h6;
   logic [15:0]  digital_input = 16'h1234;
   logic [15:0]  digital_output;
   logic [11:0]  analog_out_code;
   logic [7:0]   bus_rdata, irq_line, d;
   logic         dma_ack, dma_tc, dma_req, adc_start;
   logic         bus_rdata_oe_n, analog_out_load, oe;
   int           num_errors = 0, n_compared = 0, starts = 0, acks = 0;
   int           cycles = 0, s0, a0;
   dqc_tb_row_t  rows [4] = '{'{8'h00, 3'h1}, '{8'h01, 3'h1},
                              '{8'h02, 3'h2}, '{8'h03, 3'h4}};

   always #4 ref_clk = ~ref_clk;

   dqc_host_port u_dqc_host_port (.ref_clk, .nrst, .bus_req, .bus_rdata,
      .bus_rdata_oe_n, .pacer_out, .external_trigger_input, .adc_start,
      .adc_busy, .adc_done, .adc_result, .next_channel, .input_differential,
      .dma_ack, .dma_tc, .dma_req, .irq_line, .analog_out_code,
      .analog_out_load, .digital_input, .digital_output);
   dqc_dma_model u_dqc_dma_model (.ref_clk, .nrst, .dma_req, .ack_delay,
      .dma_ack, .dma_tc);

   task automatic report_and_stop();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bwr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      bus_req <= '{1'b0, 1'b1, a, v};
      @(posedge ref_clk);
      bus_req <= '{1'b0, 1'b0, a, v};
      @(negedge ref_clk);
   endtask

   task automatic brd(input logic [3:0] a);
      @(posedge ref_clk);
      bus_req <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge ref_clk);
      bus_req <= '{1'b0, 1'b0, a, 8'h00};
      @(negedge ref_clk);
      d = bus_rdata;
      oe = bus_rdata_oe_n;
   endtask

   task automatic pulse(input int which);
      @(posedge ref_clk);
      if (which == 1) begin
         external_trigger_input <= 1'b1;
      end else begin
         pacer_out <= 1'b1;
      end
      repeat (2) @(posedge ref_clk);
      external_trigger_input <= 1'b0;
      pacer_out <= 1'b0;
   endtask

   task automatic conv(input logic [15:0] res);
      @(posedge ref_clk);
      adc_done <= 1'b1;
      adc_result <= res;
      @(posedge ref_clk);
      adc_done <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (adc_start === 1'b1) starts++;
      if (dma_ack === 1'b1) acks++;
      if (cycles == 5000) begin
         num_errors++;
         $display("mismatch at %0t: run did not finish", $time);
         report_and_stop();
      end
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(negedge ref_clk);
      chk({analog_out_code, bus_rdata_oe_n, 3'h0}, 16'h0008); // RESET
      chk({irq_line, 7'h0, dma_req}, 16'h0000); // RESET
      // Every trigger source against every select code.
      foreach (rows[i]) begin
         bwr(4'h9, rows[i].ctl);
         brd(4'h9);
         chk({8'h00, d}, {8'h00, rows[i].ctl});
         for (int j = 0; j < 3; j++) begin
            s0 = starts;
            if (j == 0) bwr(4'h0, 8'h5A);
            else pulse(j);
            repeat (4) @(posedge ref_clk);
            chk(16'(starts - s0), {15'h0, rows[i].exp[j]});
         end
      end
      bwr(4'h3, 8'hA5);
      bwr(4'hB, 8'h3C);
      chk(digital_output, 16'h3CA5);
      brd(4'h3);
      chk({7'h0, oe, d}, 16'h0034);
      brd(4'hB);
      chk({7'h0, oe, d}, 16'h0012);
      brd(4'h2);
      chk({15'h0, oe}, 16'h0001);
      brd(4'h4);
      chk({15'h0, oe}, 16'h0001);
      bwr(4'h4, 8'hA0);
      chk({4'h0, analog_out_code}, 16'h0000);
      bwr(4'h5, 8'h3C);
      chk({3'h0, analog_out_load, analog_out_code}, 16'h13CA);
      bwr(4'h9, 8'hD0);
      @(posedge ref_clk);
      adc_busy <= 1'b1;
      conv(16'hABC5);
      brd(4'h8);
      chk({8'h00, d}, 16'h00B6);
      chk({8'h00, irq_line}, 16'h0020);
      brd(4'h0);
      chk({8'h00, d}, 16'h00C5);
      brd(4'h1);
      chk({8'h00, d}, 16'h00AB);
      @(posedge ref_clk);
      adc_busy <= 1'b0;
      input_differential <= 1'b0;
      next_channel <= 4'h9;
      bwr(4'h8, 8'h00);
      repeat (2) @(posedge ref_clk);
      brd(4'h8);
      chk({irq_line, d}, 16'h0009);
      bwr(4'h9, 8'hD4);
      for (int k = 0; k < 2; k++) begin
         ack_delay <= 3'(4 * k);
         a0 = acks;
         conv(16'h1230);
         chk({8'h00, irq_line}, 16'h0000);
         for (int t = 0; t < 60 && acks < a0 + 2; t++) @(posedge ref_clk);
         repeat (4) @(posedge ref_clk);
         @(negedge ref_clk);
         chk(16'(acks - a0), 16'h0002);
         chk({8'h00, irq_line}, 16'h0020);
         bwr(4'h8, 8'h00);
      end
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      brd(4'h9);
      chk({d, digital_output[7:0]}, 16'h0000); // RESET
      report_and_stop();
   end
endmodule // tb_dqc_host_port
